// ==== hdl/pin_ctrl_pkg.sv ====
/*
 * Shared constants for the general-purpose pin control block: register
 * offsets, field positions, reset values, function codes and timing counts.
 * Assumes a 250 MHz register clock and an 18-bit byte address on APB.
 */
package pin_ctrl_pkg;

   // Register word indices; each register is one aligned 32-bit word.
   localparam logic [15:0] CTRL_INDEX = 16'h4038;
   localparam logic [15:0] DATA_INDEX = 16'h403c;

   // Register byte addresses on the APB bus: four times the word index.
   localparam logic [17:0] CTRL_OFFSET = {CTRL_INDEX, 2'b00};
   localparam logic [17:0] DATA_OFFSET = {DATA_INDEX, 2'b00};

   // Field positions inside the control register.
   localparam int DIR_BIT = 15;
   localparam int PULL_HI = 14;
   localparam int PULL_LO = 13;
   localparam int EDGE_BIT = 12;
   localparam int DOM_BIT = 11;
   localparam int POL_BIT = 10;
   localparam int DRV_BIT = 9;
   localparam int ENA_BIT = 7;
   localparam int FN_HI = 3;

   // Reset value and writable bits of the control register.
   localparam logic [15:0] CTRL_RESET = 16'ha400;
   localparam logic [15:0] CTRL_WMASK = 16'hfe8f;

   // Field positions inside the data register.
   localparam int OUT_VAL_BIT = 0;
   localparam int PIN_LVL_BIT = 1;
   localparam int RAW_BIT = 2;

   // Pull selector codes.
   localparam logic [1:0] PULL_NONE = 2'h0;
   localparam logic [1:0] PULL_DOWN = 2'h1;
   localparam logic [1:0] PULL_UP = 2'h2;

   // Function codes that need special handling.
   localparam logic [3:0] FN_IN_LONG = 4'h0;
   localparam logic [3:0] FN_SLEEP_WAKE_LONG = 4'h4;
   localparam logic [3:0] FN_HWCTL1_LONG = 4'he;
   localparam logic [3:0] FN_HWCTL2_LONG = 4'hf;
   localparam logic [3:0] FN_OUT_REG = 4'h0;
   localparam logic [3:0] FN_OUT_RSV_LO = 4'h5;
   localparam logic [3:0] FN_OUT_RSV_HI = 4'h7;

   // Debounce timing; counts round up to whole clock cycles.
   localparam int CLK_PERIOD_NS = 4;
   localparam int SHORT_DEB_NS = 100;
   localparam int LONG_DEB_US = 30;
   localparam int DEB_W = 16;
   localparam int SHORT_DEB_CYC = (SHORT_DEB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int LONG_DEB_CYC = (LONG_DEB_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

// ==== hdl/pin_debounce.sv ====
/*
 * Debounce filter for the pin input: the filtered level follows the raw level
 * only after it has stood unchanged for the selected number of cycles.
 * Assumes the raw level is already synchronous to the clock.
 */
`timescale 1ns/10ps
module pin_debounce (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic raw,
   input wire logic [pin_ctrl_pkg::DEB_W-1:0] limit,
   output logic level
);
   import pin_ctrl_pkg::*;

   logic level_q, level_d;
   logic [DEB_W-1:0] cnt_q, cnt_d;

   // Count while the raw level differs; accept it when the count is reached.
   always_comb begin
      level_d = level_q;
      cnt_d = '0;
      if (raw != level_q) begin
         cnt_d = cnt_q + 16'h0001;
         if (cnt_d >= limit) begin
            level_d = raw;
            cnt_d = '0;
         end
      end
   end

   // Filter state registers.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         level_q <= 1'b0;
         cnt_q <= '0;
      end else begin
         level_q <= level_d;
         cnt_q <= cnt_d;
      end
   end

   assign level = level_q;
endmodule

// ==== hdl/pin_edge_detect.sv ====
/*
 * Edge detector for the pin event: one-cycle pulse on a rising edge of the
 * logical level, or on either edge when both-edge mode is selected.
 * Assumes the level is debounced and already polarity corrected.
 */
`timescale 1ns/10ps
module pin_edge_detect (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic level,
   input wire logic both_edges,
   input wire logic arm,
   output logic event_pulse
);
   logic prev_q, prev_d;
   logic event_q, event_d;

   // Compare with the level of the previous cycle.
   always_comb begin
      prev_d = level;
      if (both_edges) begin
         event_d = arm & (level ^ prev_q);
      end else begin
         event_d = arm & level & ~prev_q;
      end
   end

   // Edge state registers.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev_q <= 1'b0;
         event_q <= 1'b0;
      end else begin
         prev_q <= prev_d;
         event_q <= event_d;
      end
   end

   assign event_pulse = event_q;
endmodule

// ==== hdl/gpio_pin_control.sv ====
/*
 * Control logic for one general-purpose pin of a power-management device:
 * APB register slave, pad drive and pulls, debounced input, input function
 * decode, output function multiplexer and edge event generation.
 * Assumes a single 250 MHz clock, pin inputs synchronous to it, and an
 * interrupt controller outside that takes the one-cycle edge event.
 */
// Overview of operation
// RULE1: Direction bit 15: 0 output, 1 input; resets to input.
// RULE2: Pull bits 14:13: 00 none, 01 down, 10 up, 11 reserved; reset 01.
// RULE3: Edge mode 0: single edge, rising if polarity 1, falling if 0.
// RULE4: Edge mode 1: event on both pin edges whatever the polarity.
// RULE5: Supply bit 11: 0 interface supply, 1 always-on regulator; reset 0.
// RULE6: Polarity bit 10: 0 active low, 1 active high; reset 1; both directions.
// RULE7: Driver bit 9: 0 push-pull, 1 open-drain; reset 0.
// RULE8: Enable bit 7: 0 pin tri-stated, 1 normal; reset 0.
// RULE9: Input codes 0 to 7: pin inputs, power, sleep/wake, sleep, power-on, watchdog.
// RULE10: Input codes 8 to 15: scaling selects, hardware enables, hardware controls.
// RULE11: Output codes 0 to 4: register value, slow clock, ON, SLEEP, state change.
// RULE12: Output codes 8 to 15: scaling done, power enables, supply good, clock, reset.
`timescale 1ns/10ps
module gpio_pin_control #(
   parameter int LONG_DEB_CYCLES = pin_ctrl_pkg::LONG_DEB_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [17:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic pad_in,
   output logic pad_out,
   output logic pad_oe_n,
   output logic pull_up_en,
   output logic pull_down_en,
   output logic supply_sel,
   input wire logic [15:0] out_src,
   output logic [15:0] input_func_active,
   output logic edge_event
);
   import pin_ctrl_pkg::*;

   localparam logic [DEB_W-1:0] SHORT_LIMIT = DEB_W'(SHORT_DEB_CYC);
   localparam logic [DEB_W-1:0] LONG_LIMIT = DEB_W'(LONG_DEB_CYCLES);

   logic [15:0] ctrl_q, ctrl_d;
   logic out_val_q, out_val_d;
   logic raw_q, raw_d;
   logic [31:0] prdata_q, prdata_d;
   logic pready_q, pready_d;
   logic pslverr_q, pslverr_d;
   logic pad_out_q, pad_out_d;
   logic pad_oe_n_q, pad_oe_n_d;
   logic pull_up_q, pull_up_d;
   logic pull_down_q, pull_down_d;
   logic supply_q, supply_d;
   logic [15:0] func_q, func_d;
   logic [15:0] func_hit;
   logic deb_pad;
   logic logic_lvl;
   logic is_input;
   logic enabled;
   logic long_fn;
   logic [DEB_W-1:0] deb_limit;
   logic [3:0] fn;
   logic out_sel;
   logic out_logic;

   // Field decode of the control register.
   assign fn = ctrl_q[FN_HI:0];
   assign is_input = ctrl_q[DIR_BIT]; // see RULE1
   assign enabled = ctrl_q[ENA_BIT]; // see RULE8
   assign long_fn = (fn == FN_IN_LONG) || (fn == FN_SLEEP_WAKE_LONG) ||
                    (fn == FN_HWCTL1_LONG) || (fn == FN_HWCTL2_LONG);
   assign deb_limit = long_fn ? LONG_LIMIT : SHORT_LIMIT; // see RULE9
   // The logical level is the debounced pad level with polarity applied.
   assign logic_lvl = deb_pad ^ ~ctrl_q[POL_BIT]; // see RULE6

   // APB slave: answer one cycle after setup, write at the completing edge.
   always_comb begin
      ctrl_d = ctrl_q;
      out_val_d = out_val_q;
      prdata_d = prdata_q;
      pslverr_d = pslverr_q;
      pready_d = psel & ~penable;
      raw_d = pad_in;
      if (psel && !penable) begin
         prdata_d = 32'h0000_0000;
         pslverr_d = 1'b0;
         if (paddr == CTRL_OFFSET) begin
            prdata_d = {16'h0000, ctrl_q};
         end else if (paddr == DATA_OFFSET) begin
            prdata_d = {29'h0, raw_q, logic_lvl, out_val_q};
         end else begin
            pslverr_d = 1'b1;
         end
      end
      // Refused writes to unmapped addresses leave every register as it was.
      if (psel && penable && pready_q && pwrite && !pslverr_q) begin
         if (paddr == CTRL_OFFSET) begin
            ctrl_d = pwdata[15:0] & CTRL_WMASK;
         end else if (paddr == DATA_OFFSET) begin
            out_val_d = pwdata[OUT_VAL_BIT];
         end
      end
   end

   // Register file and bus answer registers.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= CTRL_RESET; // see RULE1
         out_val_q <= 1'b0;
         raw_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end else begin
         ctrl_q <= ctrl_d;
         out_val_q <= out_val_d;
         raw_q <= raw_d;
         prdata_q <= prdata_d;
         pready_q <= pready_d;
         pslverr_q <= pslverr_d;
      end
   end

   // Output function multiplexer; reserved codes drive inactive.
   always_comb begin
      if (fn == FN_OUT_REG) begin
         out_sel = out_val_q; // see RULE11
      end else if (fn >= FN_OUT_RSV_LO && fn <= FN_OUT_RSV_HI) begin
         out_sel = 1'b0;
      end else begin
         out_sel = out_src[fn]; // see RULE12
      end
      out_logic = out_sel ^ ~ctrl_q[POL_BIT]; // see RULE6
   end

   // Pad drive, pulls, supply and input function decode.
   always_comb begin
      pad_out_d = out_logic;
      pad_oe_n_d = 1'b1;
      pull_up_d = (ctrl_q[PULL_HI:PULL_LO] == PULL_UP); // see RULE2
      pull_down_d = (ctrl_q[PULL_HI:PULL_LO] == PULL_DOWN); // see RULE2
      supply_d = ctrl_q[DOM_BIT]; // see RULE5
      func_d = func_hit;
      if (enabled && !is_input) begin
         if (ctrl_q[DRV_BIT]) begin
            // Open drain only ever pulls low; high is left to the pull-up.
            pad_out_d = 1'b0; // see RULE7
            pad_oe_n_d = out_logic;
         end else begin
            pad_oe_n_d = 1'b0; // see RULE7
         end
      end
   end

   // One decoder per input function bit; only the selected code can go high.
   for (genvar i = 0; i < 16; i++) begin : g_func
      assign func_hit[i] = enabled & is_input & logic_lvl & (fn == 4'(i)); // see RULE9 see RULE10
   end

   // Pin side output registers; disabled pin stays tri-stated.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pad_out_q <= 1'b0;
         pad_oe_n_q <= 1'b1; // see RULE8
         pull_up_q <= 1'b0;
         pull_down_q <= 1'b1;
         supply_q <= 1'b0;
         func_q <= 16'h0000;
      end else begin
         pad_out_q <= pad_out_d;
         pad_oe_n_q <= pad_oe_n_d;
         pull_up_q <= pull_up_d;
         pull_down_q <= pull_down_d;
         supply_q <= supply_d;
         func_q <= func_d;
      end
   end

   // Debounce the pad level, short or long by function code.
   pin_debounce deb_i (
      .pclk(pclk),
      .presetn(presetn),
      .raw(raw_q),
      .limit(deb_limit),
      .level(deb_pad)
   );

   // Edge event on the logical level while the pin is an enabled input.
   pin_edge_detect edge_i (
      .pclk(pclk),
      .presetn(presetn),
      .level(logic_lvl),
      .both_edges(ctrl_q[EDGE_BIT]), // see RULE4
      .arm(enabled & is_input), // see RULE3
      .event_pulse(edge_event)
   );

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign pad_out = pad_out_q;
   assign pad_oe_n = pad_oe_n_q;
   assign pull_up_en = pull_up_q;
   assign pull_down_en = pull_down_q;
   assign supply_sel = supply_q;
   assign input_func_active = func_q;

   // Checks on the pin behaviour.
   input_hiz_a: assert property ( // see RULE1
      @(posedge pclk) disable iff (!presetn)
      is_input |=> pad_oe_n)
      else $error("Input pin is driven.");

   pull_map_a: assert property ( // see RULE2
      @(posedge pclk) disable iff (!presetn)
      (ctrl_q[PULL_HI:PULL_LO] == 2'h3) |=> !pull_up_en && !pull_down_en)
      else $error("Reserved pull code enables a pull.");

   single_edge_a: assert property ( // see RULE3
      @(posedge pclk) disable iff (!presetn)
      (enabled && is_input && !ctrl_q[EDGE_BIT] && $fell(logic_lvl)) |=> !edge_event)
      else $error("Event raised on the inactive edge.");

   both_edge_a: assert property ( // see RULE4
      @(posedge pclk) disable iff (!presetn)
      (enabled && is_input && ctrl_q[EDGE_BIT] && $changed(logic_lvl)) |=> edge_event)
      else $error("Edge missed in both-edge mode.");

   supply_sel_a: assert property ( // see RULE5
      @(posedge pclk) disable iff (!presetn)
      $changed(ctrl_q[DOM_BIT]) |=> supply_sel == $past(ctrl_q[DOM_BIT]))
      else $error("Supply select does not follow the register.");

   out_polarity_a: assert property ( // see RULE6
      @(posedge pclk) disable iff (!presetn)
      (enabled && !is_input && !ctrl_q[DRV_BIT] && fn == FN_OUT_REG)
      |=> !pad_oe_n && pad_out == ($past(out_val_q) ^ ~$past(ctrl_q[POL_BIT])))
      else $error("Output level ignores polarity.");

   open_drain_a: assert property ( // see RULE7
      @(posedge pclk) disable iff (!presetn)
      (enabled && !is_input && ctrl_q[DRV_BIT]) |=> !pad_out)
      else $error("Open-drain pin drives high.");

   tristate_a: assert property ( // see RULE8
      @(posedge pclk) disable iff (!presetn)
      !enabled |=> pad_oe_n && input_func_active == 16'h0000)
      else $error("Disabled pin is active.");

   in_func_low_a: assert property ( // see RULE9
      @(posedge pclk) disable iff (!presetn)
      (enabled && is_input && logic_lvl && !fn[3]) |=> input_func_active == (16'h0001 << $past(fn)))
      else $error("Low input function not decoded.");

   in_func_high_a: assert property ( // see RULE10
      @(posedge pclk) disable iff (!presetn)
      (enabled && is_input && logic_lvl && fn[3]) |=> input_func_active == (16'h0001 << $past(fn)))
      else $error("High input function not decoded.");

   out_func_low_a: assert property ( // see RULE11
      @(posedge pclk) disable iff (!presetn)
      (enabled && !is_input && !ctrl_q[DRV_BIT] && ctrl_q[POL_BIT] && fn >= 4'h1 && fn <= 4'h4)
      |=> pad_out == $past(out_src[fn]))
      else $error("Low output function not routed.");

   out_func_high_a: assert property ( // see RULE12
      @(posedge pclk) disable iff (!presetn)
      (enabled && !is_input && !ctrl_q[DRV_BIT] && ctrl_q[POL_BIT] && fn[3])
      |=> pad_out == $past(out_src[fn]))
      else $error("High output function not routed.");

   // Checks on the register bus.
   apb_ready_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (psel && !penable) |=> pready)
      else $error("No ready one cycle after setup.");

   apb_pulse_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (pready && psel && penable) |=> !pready)
      else $error("Ready stands longer than one cycle.");

   unmapped_err_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (psel && !penable && paddr != CTRL_OFFSET && paddr != DATA_OFFSET)
      |=> pready && pslverr)
      else $error("Unmapped address not refused.");

   ctrl_write_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (psel && penable && pready && pwrite && paddr == CTRL_OFFSET)
      |=> ctrl_q == ($past(pwdata[15:0]) & CTRL_WMASK))
      else $error("Control write did not land.");

   // Further checks on the pin.
   pull_up_a: assert property ( // see RULE2
      @(posedge pclk) disable iff (!presetn)
      (ctrl_q[PULL_HI:PULL_LO] == PULL_UP) |=> pull_up_en && !pull_down_en)
      else $error("Pull-up code not applied.");

   pull_down_a: assert property ( // see RULE2
      @(posedge pclk) disable iff (!presetn)
      (ctrl_q[PULL_HI:PULL_LO] == PULL_DOWN) |=> pull_down_en && !pull_up_en)
      else $error("Pull-down code not applied.");

   rise_event_a: assert property ( // see RULE3
      @(posedge pclk) disable iff (!presetn)
      (enabled && is_input && !ctrl_q[EDGE_BIT] && $rose(logic_lvl)) |=> edge_event)
      else $error("Active edge missed in single-edge mode.");

   push_pull_a: assert property ( // see RULE7
      @(posedge pclk) disable iff (!presetn)
      (enabled && !is_input && !ctrl_q[DRV_BIT]) |=> !pad_oe_n)
      else $error("Push-pull output not driven.");

   edge_disarm_a: assert property ( // see RULE8
      @(posedge pclk) disable iff (!presetn)
      !enabled |=> !edge_event)
      else $error("Disabled pin raised an event.");

   output_no_func_a: assert property ( // see RULE1
      @(posedge pclk) disable iff (!presetn)
      !is_input |=> input_func_active == 16'h0000)
      else $error("Output pin reports an input function.");

   // Main scenarios.
   ctrl_write_c: cover property (@(posedge pclk) disable iff (!presetn)
      psel && penable && pready && pwrite && paddr == CTRL_OFFSET);
   both_event_c: cover property (@(posedge pclk) disable iff (!presetn)
      ctrl_q[EDGE_BIT] && edge_event);
   open_drain_c: cover property (@(posedge pclk) disable iff (!presetn)
      ctrl_q[DRV_BIT] && !pad_oe_n);
   long_deb_c: cover property (@(posedge pclk) disable iff (!presetn)
      long_fn && is_input && $rose(deb_pad));
   single_event_c: cover property (@(posedge pclk) disable iff (!presetn)
      !ctrl_q[EDGE_BIT] && edge_event);
endmodule

// ==== dv/pad_partner.sv ====
/*
 * Model of the wire outside the general-purpose pin: an outside driver,
 * the block's own pad driver and the pull resistors decide the level.
 * Assumes the bench drives ext_en and ext_val on the clock edge.
 */
`timescale 1ns/10ps
module pad_partner (
   input wire logic pclk,
   input wire logic pad_out,
   input wire logic pad_oe_n,
   input wire logic pull_up_en,
   input wire logic pull_down_en,
   input wire logic ext_en,
   input wire logic ext_val,
   output logic pad_in
);
   logic level;

   // An outside driver wins, then the block's driver, then the pulls.
   always_comb begin
      if (ext_en) begin
         level = ext_val;
      end else if (!pad_oe_n) begin
         level = pad_out;
      end else if (pull_up_en) begin
         level = 1'b1;
      end else if (pull_down_en) begin
         level = 1'b0;
      end else begin
         level = ~pad_in;
      end
   end

   // A floating wire wanders every cycle so that no stale level looks valid.
   always_ff @(posedge pclk) begin
      pad_in <= level;
   end
endmodule

// ==== dv/tb_top.sv ====
/*
 * Self-checking bench for the pin control block: registers over APB,
 * output routing, pad drive, pulls, input functions and edge events.
 * Assumes the design under hdl/ and the pad model in pad_partner.sv.
 */
`timescale 1ns/10ps
module tb_top;
   import pin_ctrl_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [17:0] paddr = 18'h0;
   logic [31:0] pwdata = 32'h0;
   logic [15:0] out_src = 16'h0;
   logic ext_en = 1'b0;
   logic ext_val = 1'b0;
   logic [31:0] prdata, rd;
   logic pready, pslverr, pad_in, pad_out, pad_oe_n, pull_up_en, pull_down_en;
   logic supply_sel, edge_event, err, pol, mode, od, dv, lvl;
   logic [15:0] input_func_active, ctl;
   logic [3:0] code;
   logic [1:0] pull;
   int error_cnt = 0;
   int compares = 0;
   int ev_cnt = 0;
   int ev0;

   // Clock at 250 MHz.
   always #2 pclk = ~pclk;

   gpio_pin_control #(.LONG_DEB_CYCLES(8)) dut (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .pad_in(pad_in),
      .pad_out(pad_out), .pad_oe_n(pad_oe_n), .pull_up_en(pull_up_en),
      .pull_down_en(pull_down_en), .supply_sel(supply_sel), .out_src(out_src),
      .input_func_active(input_func_active), .edge_event(edge_event));

   pad_partner pad (.pclk(pclk), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
      .pull_up_en(pull_up_en), .pull_down_en(pull_down_en), .ext_en(ext_en),
      .ext_val(ext_val), .pad_in(pad_in));

   // Counts edge event pulses.
   always @(posedge pclk) begin
      if (edge_event === 1'b1) begin
         ev_cnt <= ev_cnt + 1;
      end
   end

   // Expected pad level, polarity applied, for an output function code.
   function automatic logic exp_lvl(logic [3:0] c, logic [15:0] s, logic d, logic p);
      logic v;
      v = (c == 4'h0) ? d : ((c >= 4'h5 && c <= 4'h7) ? 1'b0 : s[c]);
      return v ^ ~p;
   endfunction

   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // One APB transfer; waits for pready under a bound.
   task automatic apb(input logic wr, input logic [17:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 100);
      if (pready !== 1'b1) begin
         error_cnt++;
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic settle();
      repeat (40) @(posedge pclk);
   endtask

   task automatic conclude();
      if (error_cnt == 0 && compares > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // Cuts a hang short.
   initial begin
      repeat (20000) @(posedge pclk);
      error_cnt++;
      conclude();
   end

   // Main sequence.
   initial begin
      void'($urandom(32'h233317db));
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk("pad_oe_n", pad_oe_n, 1'b1);
      chk("pull_down_en", pull_down_en, 1'b1);
      chk("supply_sel", supply_sel, 1'b0);
      apb(1'b0, CTRL_OFFSET, 32'h0, rd, err);
      chk("ctrl reset", rd, 32'ha400);
      apb(1'b0, 18'h100c0, 32'h0, rd, err);
      chk("unmapped err", err, 1'b1);
      chk("unmapped data", rd, 32'h0);
      // Output functions, random polarity, driver, pull and sources.
      for (int i = 0; i < 16; i++) begin
         code = i[3:0];
         pol = 1'($urandom);
         od = 1'($urandom);
         dv = 1'($urandom);
         pull = 2'($urandom);
         out_src <= 16'($urandom);
         ctl = {1'b0, pull, 1'b0, 1'($urandom), pol, od, 1'b0, 1'b1, 3'h0, code};
         apb(1'b1, DATA_OFFSET, {31'h0, dv}, rd, err);
         apb(1'b1, CTRL_OFFSET, {16'h0, ctl}, rd, err);
         repeat (3) @(posedge pclk);
         lvl = exp_lvl(code, out_src, dv, pol);
         chk("pad_oe_n", pad_oe_n, od & lvl);
         chk("pad_out", pad_out, ~od & lvl);
         chk("pull_up_en", pull_up_en, pull == 2'h2);
         chk("pull_down_en", pull_down_en, pull == 2'h1);
         chk("supply_sel", supply_sel, ctl[11]);
         apb(1'b0, CTRL_OFFSET, 32'h0, rd, err);
         chk("ctrl", rd, {16'h0, ctl & CTRL_WMASK});
      end
      // Input functions and edge events in every mode and polarity.
      for (int i = 0; i < 16; i++) begin
         code = i[3:0];
         mode = code[0];
         pol = code[1];
         ext_en <= 1'b0;
         ctl = {1'b1, 2'h1, mode, 1'b0, pol, 1'b0, 1'b0, 1'b1, 3'h0, code};
         apb(1'b1, CTRL_OFFSET, {16'h0, ctl}, rd, err);
         settle();
         ev0 = ev_cnt;
         ext_en <= 1'b1;
         ext_val <= 1'b1;
         settle();
         chk("func high", input_func_active, pol ? 16'h1 << code : 16'h0);
         chk("events rise", 32'(ev_cnt - ev0), pol | mode);
         apb(1'b0, DATA_OFFSET, 32'h0, rd, err);
         chk("data rd", rd, {29'h0, 1'b1, pol, dv});
         ext_val <= 1'b0;
         settle();
         chk("func low", input_func_active, pol ? 16'h0 : 16'h1 << code);
         chk("events fall", 32'(ev_cnt - ev0), (pol | mode) + (!pol | mode));
      end
      // A disabled pin neither drives nor reports.
      apb(1'b1, CTRL_OFFSET, 32'h0401, rd, err);
      repeat (3) @(posedge pclk);
      chk("pad_oe_n off", pad_oe_n, 1'b1);
      apb(1'b1, CTRL_OFFSET, 32'h9401, rd, err);
      settle();
      ev0 = ev_cnt;
      ext_val <= 1'b1;
      settle();
      chk("func off", input_func_active, 16'h0);
      chk("events off", 32'(ev_cnt - ev0), 32'h0);
      conclude();
   end
endmodule
